// ---- bench/gep_group_cfg_properties.sv ----
`timescale 1ns/10ps
module gep_group_cfg_properties
	import gep_pkg::*;
#(
	parameter int SLOTS = 32,
	parameter int PORTS = 4
) (
	// Clock, reset and register port.
	input wire logic                 clk, rst_n, clk_en, write, read,
	input wire logic [7:0]           addr,
	input wire logic [31:0]          wdata, rdata,
	// Slot map and gated enables.
	input wire logic [SLOTS-1:0]     slot_tx_enable, slot_rx_enable, slot_sub_enable,
	input wire logic [SLOTS-1:0]     eff_tx_enable, eff_rx_enable, eff_sub_enable,
	// Configuration outputs.
	input wire logic                 tx_data_oe_n, ext_buffer_enable, protection_enable,
	input wire logic [11:0]          protection_high_bound, protection_low_bound,
	input wire logic [PORTS*32-1:0]  port_cfg
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////////
	sub_gate_a: assert property (ext_buffer_enable |-> eff_sub_enable == '0)
		else $error("subchannel enable leaked");
	sub_pass_a: assert property ($past(clk_en & rst_n) && !ext_buffer_enable
		|-> eff_sub_enable == $past(slot_sub_enable)) else $error("subchannel pass wrong");
	tx_gate_a: assert property (tx_data_oe_n |-> eff_tx_enable == '0)
		else $error("tx enable leaked");
	tx_pass_a: assert property ($past(clk_en & rst_n) && !tx_data_oe_n
		|-> eff_tx_enable == $past(slot_tx_enable)) else $error("tx pass wrong");
	rx_gate_a: assert property ($past(clk_en & rst_n)
		|-> (eff_rx_enable & ~$past(slot_rx_enable)) == '0) else $error("rx enable leaked");
	prot_win_a: assert property (clk_en && write && addr == GEP_OFF_PROT_WIN |=>
		{protection_high_bound, protection_low_bound} == {$past(wdata[27:16]),
		$past(wdata[11:0])}) else $error("protection bounds wrong");
	port_cfg_a: assert property (clk_en && write && addr == GEP_OFF_PORT_CFG0
		|=> port_cfg[31:0] == ($past(wdata) & GEP_PC_MASK)) else $error("port cfg wrong");
	rd_idle_a: assert property ($past(clk_en & rst_n) && !$past(read) |-> rdata == '0)
		else $error("read data not idle");
	grp_cfg_a: assert property (clk_en && write && addr == GEP_OFF_GROUP_CFG ##1 clk_en
		|=> ext_buffer_enable == $past(wdata[2], 2) && tx_data_oe_n == !$past(wdata[1], 2))
		else $error("group derived outputs wrong");
	cov_grp_c: cover property (clk_en && write && addr == GEP_OFF_GROUP_CFG);
	cov_rd_c: cover property (read ##1 rdata != '0);
	cov_tx_c: cover property ($fell(tx_data_oe_n));
endmodule

// ---- bench/test_group_enable_and_protect_config.sv ----
`timescale 1ns/10ps
module test_group_enable_and_protect_config;
	import gep_pkg::*;
	logic         clk, rst_n, clk_en, write, read;
	logic         tx_data_oe_n, ext_buffer_enable, protection_enable;
	logic [7:0]   addr;
	logic [31:0]  wdata, rdata, slot_tx_enable, slot_rx_enable, slot_sub_enable;
	logic [31:0]  eff_tx_enable, eff_rx_enable, eff_sub_enable;
	logic [11:0]  protection_high_bound, protection_low_bound;
	logic [127:0] port_cfg;
	int           error_cnt, n_tests;
	gep_group_cfg gep_group_cfg_inst (.*);
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		write <= 1'b1;
		@(posedge clk);
		write <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe.
	task automatic rd(logic [7:0] a, logic [31:0] e);
		@(posedge clk);
		addr <= a;
		read <= 1'b1;
		@(posedge clk);
		read <= 1'b0;
		#1 chk("rdata", rdata, e);
	endtask
	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		{rst_n, write, read, addr, wdata} = '0;
		clk_en          = 1'b1;
		slot_tx_enable  = 32'hA5A5_0F0F;
		slot_rx_enable  = 32'h3C3C_F00F;
		slot_sub_enable = 32'h0FF0_1234;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1 chk("oe_n", tx_data_oe_n, 1);
		wr(GEP_OFF_GROUP_CFG, 32'h0000_0006);
		settle;
		chk("etx", eff_tx_enable, slot_tx_enable);
		chk("erx", eff_rx_enable, 0);
		chk("esub", eff_sub_enable, 0);
		chk("extb", ext_buffer_enable, 1);
		chk("oe_n", tx_data_oe_n, 0);
		wr(GEP_OFF_GROUP_CFG, 32'hFFFF_FFF9);
		settle;
		chk("etx", eff_tx_enable, 0);
		chk("erx", eff_rx_enable, slot_rx_enable);
		chk("esub", eff_sub_enable, slot_sub_enable);
		chk("oe_n", tx_data_oe_n, 1);
		rd(GEP_OFF_GROUP_CFG, 32'h0000_0001);
		$display("group test done");
		wr(GEP_OFF_PROT_WIN, 32'h7ABC_5DEF);
		rd(GEP_OFF_PROT_WIN, 32'h0ABC_0DEF);
		chk("pen", protection_enable, 0);
		chk("hi", protection_high_bound, 32'hABC);
		chk("lo", protection_low_bound, 32'hDEF);
		$display("protection test done");
		for (int p = 0; p < 4; p++) wr(GEP_OFF_PORT_CFG0 + 8'(4 * p), 32'h100 + p);
		#1 for (int p = 0; p < 4; p++) chk("port", port_cfg[p*32+:32], 32'h100 + p);
		wr(GEP_OFF_GLOBAL_CFG, 32'h1);
		settle;
		rd(GEP_OFF_STATUS, 32'h1);
		wr(GEP_OFF_PORT_CFG0 + 8'h04, 32'h100);
		wr(GEP_OFF_PORT_CFG0 + 8'h0C, 32'h102);
		settle;
		rd(GEP_OFF_STATUS, 32'h0);
		wr(GEP_OFF_GLOBAL_CFG, 32'h2);
		settle;
		rd(GEP_OFF_STATUS, 32'h1);
		$display("port test done");
		wr(8'h40, 32'hFFFF_FFFF);
		rd(8'h40, 32'h0);
		rd(GEP_OFF_GROUP_CFG, 32'h0000_0001);
		$display("unmapped test done");
		// A write while the clock enable is low must leave every register alone.
		@(posedge clk);
		clk_en <= 1'b0;
		wr(GEP_OFF_GROUP_CFG, 32'h0000_0002);
		@(posedge clk);
		clk_en <= 1'b1;
		rd(GEP_OFF_GROUP_CFG, 32'h0000_0001);
		$display("freeze test done");
		conclude;
	end
endmodule
bind gep_group_cfg gep_group_cfg_properties #(.SLOTS(SLOTS), .PORTS(PORTS))
	gep_group_cfg_properties_inst (.*);

// ---- src/gep_group_cfg.sv ----
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module gep_group_cfg
	import gep_pkg::*;
#(
	parameter int SLOTS = 32,
	parameter int PORTS = 4
) (
	// Clock and reset.
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               clk_en,
	// Register port.
	input  wire logic [7:0]         addr,
	input  wire logic [31:0]        wdata,
	input  wire logic               write,
	input  wire logic               read,
	output logic      [31:0]        rdata,
	// Per-slot enables from the time slot map, left untouched.
	input  wire logic [SLOTS-1:0]   slot_tx_enable,
	input  wire logic [SLOTS-1:0]   slot_rx_enable,
	input  wire logic [SLOTS-1:0]   slot_sub_enable,
	// Gated enables and configuration outputs to the channel engines.
	output logic      [SLOTS-1:0]   eff_tx_enable,
	output logic      [SLOTS-1:0]   eff_rx_enable,
	output logic      [SLOTS-1:0]   eff_sub_enable,
	output logic                    tx_data_oe_n,
	output logic                    ext_buffer_enable,
	output logic                    protection_enable,
	output logic      [11:0]        protection_high_bound,
	output logic      [11:0]        protection_low_bound,
	output logic      [PORTS*32-1:0] port_cfg
);

	////////////////////////////////////////////////////////////////////////////

	typedef struct packed {
		logic [31:0]          group_configuration;
		logic [31:0]          memory_protection_window;
		logic [PORTS*32-1:0]  port_cfg;
		logic [31:0]          global_cfg;
		logic [31:0]          rdata;
		logic [SLOTS-1:0]     eff_tx;
		logic [SLOTS-1:0]     eff_rx;
		logic [SLOTS-1:0]     eff_sub;
		logic                 tx_oe_n;
		logic                 ext_buf;
		logic                 mismatch;
	} gep_state_t;

	gep_state_t state;
	gep_state_t next_state;
	gep_bus_req_t req;

	assign req = '{write: write, read: read, addr: addr, wdata: wdata};

	// Word select of one port descriptor out of the packed array.
	function automatic logic [31:0] port_word(input logic [PORTS*32-1:0] pc, input int idx);
		port_word = pc[idx*32 +: 32];
	endfunction

	// Checks that combined ports hold identical descriptors.
	function automatic logic combine_mismatch(input logic [PORTS*32-1:0] pc,
		input logic [1:0] sel);
		logic bad;
		bad = 1'b0;
		if (PORTS >= 4) begin
			if (sel == 2'h1) begin
				bad = (port_word(pc, 1) != port_word(pc, 0)) ||
				      (port_word(pc, 3) != port_word(pc, 2));
			end
			if (sel == 2'h2) begin
				bad = (port_word(pc, 1) != port_word(pc, 0)) ||
				      (port_word(pc, 2) != port_word(pc, 0)) ||
				      (port_word(pc, 3) != port_word(pc, 0));
			end
		end
		combine_mismatch = bad;
	endfunction

	////////////////////////////////////////////////////////////////////////////

	always_comb begin
		logic tx_on;
		logic rx_on;
		logic sub_off;
		tx_on = 1'b0;
		rx_on = 1'b0;
		sub_off = 1'b0;
		next_state = state;
		next_state.rdata = 32'h0000_0000;
		if (req.write) begin
			if (req.addr == GEP_OFF_GROUP_CFG) begin
				next_state.group_configuration = req.wdata & GEP_GC_MASK;
			end
			if (req.addr == GEP_OFF_PROT_WIN) begin
				next_state.memory_protection_window = req.wdata & GEP_PW_MASK;
			end
			if (req.addr == GEP_OFF_GLOBAL_CFG) begin
				next_state.global_cfg = req.wdata & GEP_GL_MASK;
			end
			for (int p = 0; p < PORTS; p++) begin
				if (req.addr == GEP_OFF_PORT_CFG0 + 8'(p * 4)) begin
					next_state.port_cfg[p*32 +: 32] = req.wdata & GEP_PC_MASK;
				end
			end
		end
		if (req.read) begin
			if (req.addr == GEP_OFF_GROUP_CFG) begin
				next_state.rdata = state.group_configuration;
			end
			if (req.addr == GEP_OFF_PROT_WIN) begin
				next_state.rdata = state.memory_protection_window;
			end
			if (req.addr == GEP_OFF_GLOBAL_CFG) begin
				next_state.rdata = state.global_cfg;
			end
			if (req.addr == GEP_OFF_STATUS) begin
				next_state.rdata[GEP_ST_MISMATCH_BIT] = state.mismatch;
				next_state.rdata[GEP_ST_EXTBUF_BIT] = state.ext_buf;
			end
			for (int p = 0; p < PORTS; p++) begin
				if (req.addr == GEP_OFF_PORT_CFG0 + 8'(p * 4)) begin
					next_state.rdata = port_word(state.port_cfg, p);
				end
			end
		end
		tx_on = state.group_configuration[GEP_GC_TXEN_BIT];
		rx_on = state.group_configuration[GEP_GC_RXEN_BIT];
		sub_off = state.group_configuration[GEP_GC_SUBD_BIT];
		next_state.eff_tx = tx_on ? slot_tx_enable : '0;
		next_state.eff_rx = rx_on ? slot_rx_enable : '0;
		next_state.eff_sub = sub_off ? '0 : slot_sub_enable;
		next_state.ext_buf = sub_off;
		next_state.tx_oe_n = ~tx_on;
		next_state.mismatch = combine_mismatch(state.port_cfg,
			state.global_cfg[GEP_PCS_LSB +: 2]);
	end

	////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= '0;
			state.group_configuration <= GEP_GC_RESET;
			state.memory_protection_window <= GEP_PW_RESET;
			state.global_cfg <= GEP_GL_RESET;
			state.port_cfg <= {PORTS{GEP_PC_RESET}};
			state.tx_oe_n <= 1'b1;
		end else if (clk_en) begin
			state <= next_state;
		end
	end

	assign rdata = state.rdata;
	assign eff_tx_enable = state.eff_tx;
	assign eff_rx_enable = state.eff_rx;
	assign eff_sub_enable = state.eff_sub;
	assign tx_data_oe_n = state.tx_oe_n;
	assign ext_buffer_enable = state.ext_buf;
	assign protection_enable = state.memory_protection_window[GEP_PW_EN_BIT];
	assign protection_high_bound = state.memory_protection_window[GEP_PW_HI_LSB +: GEP_PW_BOUND_W];
	assign protection_low_bound = state.memory_protection_window[GEP_PW_LO_LSB +: GEP_PW_BOUND_W];
	assign port_cfg = state.port_cfg;

endmodule

// ---- src/gep_pkg.sv ----
package gep_pkg;

	// Register byte addresses.
	localparam logic [7:0] GEP_OFF_GROUP_CFG  = 8'h00;
	localparam logic [7:0] GEP_OFF_PROT_WIN   = 8'h04;
	localparam logic [7:0] GEP_OFF_PORT_CFG0  = 8'h10;
	localparam logic [7:0] GEP_OFF_GLOBAL_CFG = 8'h20;
	localparam logic [7:0] GEP_OFF_STATUS     = 8'h24;

	// Group configuration fields.
	localparam int GEP_GC_RXEN_BIT  = 0;
	localparam int GEP_GC_TXEN_BIT  = 1;
	localparam int GEP_GC_SUBD_BIT  = 2;
	localparam logic [31:0] GEP_GC_MASK  = 32'h0000_0007;
	localparam logic [31:0] GEP_GC_RESET = 32'h0000_0000;

	// Memory protection fields.
	localparam int GEP_PW_EN_BIT = 31;
	localparam int GEP_PW_HI_LSB = 16;
	localparam int GEP_PW_LO_LSB = 0;
	localparam int GEP_PW_BOUND_W = 12;
	localparam logic [31:0] GEP_PW_MASK  = 32'h8FFF_0FFF;
	localparam logic [31:0] GEP_PW_RESET = 32'h0000_0000;

	// Port configuration fields.
	localparam logic [31:0] GEP_PC_MASK  = 32'h0000_03F7;
	localparam logic [31:0] GEP_PC_RESET = 32'h0000_0000;

	// Global configuration: port combining select.
	localparam int GEP_PCS_LSB = 0;
	localparam logic [31:0] GEP_GL_MASK  = 32'h0000_0003;
	localparam logic [31:0] GEP_GL_RESET = 32'h0000_0000;

	// Status bits.
	localparam int GEP_ST_MISMATCH_BIT = 0;
	localparam int GEP_ST_EXTBUF_BIT   = 1;

	typedef struct packed {
		logic        write;
		logic        read;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} gep_bus_req_t;

endpackage
